// >>> hdl/ats_mode_ctrl.sv
// mode and sequence controller of an automatic transfer switch unit
// assumes voltage supervision outside reports line health as levels
`timescale 1ns/1ps
// Operation
// RULE_01 - wait selected delay before switch or back-switch
// RULE_02 - first range: 0/5/10/30 s, back equals switch
// RULE_03 - second range: same choices, back fixed 300 s
// RULE_04 - thresholds 5..20 percent, larger variant to 30
// RULE_05 - unbalance limit equals voltage threshold
// RULE_06 - setup only from manual with selector at SETUP
// RULE_07 - auto key steps six mode/type combinations
// RULE_08 - selector at TEST runs stepwise test sequence
// RULE_09 - gen start, to II, to I, gen stop
// RULE_10 - after last test step restart from first
// RULE_11 - leaving TEST gives manual; one press gives auto
// RULE_12 - no priority: stay on line 2 until failure
// RULE_13 - manual back: never back-switch, line 2 fail opens
// RULE_14 - display variant holds priority, type, manual back
// RULE_15 - handle attached: manual, alarm and power lit
// RULE_16 - handle removed: stay manual, alarm off
// RULE_17 - manual mode: gen control only display variant
// RULE_18 - manual selector: motor unpowered, commands blocked
// RULE_19 - handle forces manual until removed and auto pressed
// RULE_20 - switch status active when that switch closed
// RULE_21 - one-second ticks, timer restarts when condition clears
// RULE_22 - auto key ignored outside setup, test, manual return
module ats_mode_ctrl
    import ats_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = ats_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // front panel keys
    input wire logic key_auto,
    input wire logic key_one,
    input wire logic key_off,
    input wire logic key_two,
    input wire logic key_gen_start,
    input wire logic key_gen_stop,
    // rotary selectors and variant straps
    input wire logic [1:0] delay_sel,
    input wire logic delay_range,
    input wire logic [2:0] lim_sel,
    input wire logic variant_large,
    input wire logic display_variant,
    input wire logic gen_in_use,
    // display variant configuration
    input wire ats_pkg::prio_type cfg_priority,
    input wire logic cfg_motorized,
    input wire logic cfg_manual_back,
    // switch and line sense
    input wire logic handle_sense_input,
    input wire logic motor_manual_sel,
    input wire logic switch_one_status,
    input wire logic switch_two_status,
    input wire logic line_one_ok,
    input wire logic line_two_ok,
    // switch and generator commands
    output logic cmd_one_q,
    output logic cmd_off_q,
    output logic cmd_two_q,
    output logic motor_power_q,
    output logic gen_start_q,
    output logic gen_stop_q,
    // indications
    output logic auto_led_q,
    output logic alarm_led_q,
    output logic power_led_q,
    output logic [2:0] prio_led_q,
    output logic motorized_led_q,
    output logic setup_active_q,
    output logic test_active_q,
    output logic [5:0] threshold_pct_q,
    output logic [5:0] unbalance_pct_q
);
    import ats_pkg::*;

    initial begin
        if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > (1 << TICK_W)) begin
            $error("tick count out of range");
        end
    end

    logic [SYNC_W-1:0] pins, s;
    logic s_auto, s_one, s_off, s_two, s_gstart, s_gstop;
    logic s_handle, s_motman, s_sw1, s_sw2, s_l1, s_l2;
    logic s_drange, s_large, s_disp, s_gen, s_cmot, s_cmb;
    logic [1:0] s_dsel, s_cprio, cond_d, cond_q;
    logic [2:0] s_lim, setup_sel_q, lim_eff;
    logic [5:0] keys_prev_q, keys_now, press, pct_sel;
    op_mode_type mode_q;
    test_step_type step_q, step_first, step_next;
    pos_type target_q;
    prio_type prio;
    logic gen_run_q, motorized, expired, cmd_enable, gen_allowed;
    logic on_one, on_two, on_off, go_one, go_two, go_off;
    logic [TICK_W-1:0] tick_q;
    logic [SEC_W-1:0] sec_q;
    logic [8:0] sw_delay, back_delay, want_delay;

    assign pins = {key_auto, key_one, key_off, key_two, key_gen_start, key_gen_stop,
        handle_sense_input, motor_manual_sel, switch_one_status, switch_two_status,
        line_one_ok, line_two_ok, delay_sel, delay_range, lim_sel, variant_large,
        display_variant, gen_in_use, cfg_priority, cfg_motorized, cfg_manual_back};

    pin_sync #(.W(SYNC_W)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(pins),
        .sync(s)
    );

    assign {s_auto, s_one, s_off, s_two, s_gstart, s_gstop, s_handle, s_motman,
        s_sw1, s_sw2, s_l1, s_l2, s_dsel, s_drange, s_lim, s_large, s_disp, s_gen,
        s_cprio, s_cmot, s_cmb} = s;

    // key press edges
    assign keys_now = {s_auto, s_one, s_off, s_two, s_gstart, s_gstop};
    assign press = keys_now & ~keys_prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) keys_prev_q <= '0;
        else keys_prev_q <= keys_now;
    end

    // switch positions from auxiliary contacts
    assign on_one = s_sw1 & ~s_sw2; // RULE_20
    assign on_two = s_sw2 & ~s_sw1; // RULE_20
    assign on_off = ~s_sw1 & ~s_sw2;

    // effective configuration
    always_comb begin
        if (s_disp) begin
            prio = s_cmb ? PRIO_MANBACK : prio_type'(s_cprio); // RULE_14
            motorized = s_cmot; // RULE_14
        end else if (setup_sel_q >= SETUP_TYPES_SPLIT) begin
            prio = prio_type'(2'(setup_sel_q - SETUP_TYPES_SPLIT));
            motorized = 1'b1;
        end else begin
            prio = prio_type'(setup_sel_q[1:0]);
            motorized = 1'b0;
        end
    end

    // delay selection
    always_comb begin
        case (s_dsel)
            2'h0: sw_delay = DELAY_SEL0_S; // RULE_02
            2'h1: sw_delay = DELAY_SEL1_S;
            2'h2: sw_delay = DELAY_SEL2_S;
            default: sw_delay = DELAY_SEL3_S;
        endcase
        back_delay = s_drange ? BACK_FIXED_S : sw_delay; // RULE_03
    end

    // automatic transfer conditions
    always_comb begin
        go_off = (prio == PRIO_MANBACK) & on_two & ~s_l2; // RULE_13
        go_two = ~on_two & s_l2 & ((prio == PRIO_LINE2) | ~s_l1);
        case (prio)
            PRIO_LINE1: go_one = s_l1;
            PRIO_NONE: go_one = s_l1 & (~on_two | ~s_l2); // RULE_12
            PRIO_MANBACK: go_one = 1'b0; // RULE_13
            default: go_one = s_l1 & ~s_l2;
        endcase
        go_one = go_one & ~on_one & ~(on_off & (prio == PRIO_MANBACK));
        if (mode_q != MODE_AUTO) cond_d = 2'h0;
        else if (go_off) cond_d = 2'h3;
        else if (go_two) cond_d = 2'h2;
        else if (go_one) cond_d = 2'h1;
        else cond_d = 2'h0;
        want_delay = (cond_d == 2'h1) ? back_delay : sw_delay; // RULE_01
        expired = (cond_d != 2'h0) && (cond_d == cond_q) && (sec_q >= want_delay);
    end

    // one-second delay timer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cond_q <= 2'h0;
            tick_q <= '0;
            sec_q <= '0;
        end else begin
            cond_q <= cond_d;
            if (cond_d == 2'h0 || cond_d != cond_q) begin
                tick_q <= '0; // RULE_21
                sec_q <= '0;
            end else if (tick_q == TICK_W'(TICK_CYCLES_P - 1)) begin
                tick_q <= '0; // RULE_21
                if (sec_q != '1) sec_q <= sec_q + 1'b1;
            end else begin
                tick_q <= tick_q + 1'b1;
            end
        end
    end

    // operating mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= MODE_MANUAL;
        end else if (s_handle) begin
            mode_q <= MODE_MANUAL; // RULE_19
        end else begin
            case (mode_q)
                MODE_MANUAL: begin
                    if (s_lim == LIM_TEST) mode_q <= MODE_TEST; // RULE_08
                    else if (s_lim == LIM_SETUP) mode_q <= MODE_SETUP; // RULE_06
                    else if (press[5]) mode_q <= MODE_AUTO; // RULE_11 RULE_19
                end
                MODE_AUTO: if (s_lim == LIM_TEST) mode_q <= MODE_TEST;
                MODE_SETUP: if (s_lim != LIM_SETUP) mode_q <= MODE_MANUAL;
                MODE_TEST: if (s_lim != LIM_TEST) mode_q <= MODE_MANUAL; // RULE_11
                default: mode_q <= MODE_MANUAL;
            endcase
        end
    end

    // setup combination selection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) setup_sel_q <= RST_SETUP_SEL;
        else if (mode_q == MODE_SETUP && press[5])
            setup_sel_q <= (setup_sel_q == SETUP_LAST) ? '0 : setup_sel_q + 1'b1; // RULE_07
    end

    // test step order
    assign step_first = s_gen ? TEST_GEN_START : TEST_TO_TWO; // RULE_09
    always_comb begin
        case (step_q)
            TEST_GEN_START: step_next = TEST_TO_TWO;
            TEST_TO_TWO: step_next = TEST_TO_ONE;
            TEST_TO_ONE: step_next = s_gen ? TEST_GEN_STOP : step_first; // RULE_09
            default: step_next = step_first; // RULE_10
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_q <= TEST_TO_TWO;
        end else if (mode_q != MODE_TEST) begin
            step_q <= step_first;
        end else if (press[5]) begin
            step_q <= step_next; // RULE_08 RULE_22
        end
    end

    // switch target position
    assign cmd_enable = ~s_motman & ~s_handle;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            target_q <= POS_HOLD;
        end else if (!cmd_enable) begin
            target_q <= POS_HOLD; // RULE_18
        end else if (mode_q == MODE_MANUAL) begin
            if (press[3]) target_q <= POS_OFF;
            else if (press[2]) target_q <= POS_TWO;
            else if (press[4]) target_q <= POS_ONE;
        end else if (mode_q == MODE_AUTO && expired) begin
            case (cond_d)
                2'h3: target_q <= POS_OFF; // RULE_13
                2'h2: target_q <= POS_TWO; // RULE_01
                default: target_q <= POS_ONE; // RULE_01
            endcase
        end else if (mode_q == MODE_TEST && press[5]) begin
            if (step_q == TEST_TO_TWO) target_q <= POS_TWO; // RULE_09
            else if (step_q == TEST_TO_ONE) target_q <= POS_ONE; // RULE_09
        end
    end

    // generator request; setup counts as manual for gen_allowed, but the gen keys act only in manual
    assign gen_allowed = (mode_q == MODE_AUTO) | (mode_q == MODE_TEST) | s_disp; // RULE_17
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gen_run_q <= 1'b0;
        end else if (mode_q == MODE_AUTO) begin
            if (s_gen && !s_l1) gen_run_q <= 1'b1;
            else if (s_l1 && on_one) gen_run_q <= 1'b0;
        end else if (mode_q == MODE_TEST && press[5]) begin
            if (step_q == TEST_GEN_START) gen_run_q <= 1'b1; // RULE_09
            else if (step_q == TEST_GEN_STOP) gen_run_q <= 1'b0; // RULE_09
        end else if (mode_q == MODE_MANUAL && s_disp) begin
            if (press[1]) gen_run_q <= 1'b1; // RULE_17
            else if (press[0]) gen_run_q <= 1'b0;
        end
    end

    // command outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_one_q <= 1'b0;
            cmd_off_q <= 1'b0;
            cmd_two_q <= 1'b0;
            motor_power_q <= 1'b0;
            gen_start_q <= 1'b0;
            gen_stop_q <= 1'b0;
        end else begin
            cmd_one_q <= cmd_enable & (target_q == POS_ONE) & ~on_one; // RULE_18
            cmd_off_q <= cmd_enable & (target_q == POS_OFF) & ~on_off; // RULE_18
            cmd_two_q <= cmd_enable & (target_q == POS_TWO) & ~on_two; // RULE_18
            motor_power_q <= ~s_motman; // RULE_18
            gen_start_q <= gen_allowed & gen_run_q; // RULE_17
            gen_stop_q <= gen_allowed & ~gen_run_q; // RULE_17
        end
    end

    // indications
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auto_led_q <= 1'b0;
            alarm_led_q <= 1'b0;
            power_led_q <= 1'b0;
            prio_led_q <= 3'h0;
            motorized_led_q <= 1'b0;
            setup_active_q <= 1'b0;
            test_active_q <= 1'b0;
        end else begin
            auto_led_q <= (mode_q == MODE_AUTO) & ~s_handle; // RULE_15
            alarm_led_q <= s_handle; // RULE_15 RULE_16
            power_led_q <= 1'b1; // RULE_15
            prio_led_q <= (mode_q == MODE_SETUP) ? 3'h1 << prio[1:0] : 3'h0; // RULE_07
            motorized_led_q <= (mode_q == MODE_SETUP) & motorized;
            setup_active_q <= (mode_q == MODE_SETUP);
            test_active_q <= (mode_q == MODE_TEST);
        end
    end

    // voltage and unbalance thresholds
    assign lim_eff = (!s_large && s_lim > LIM_MAX_BASIC) ? LIM_MAX_BASIC : s_lim; // RULE_04
    assign pct_sel = 6'(({3'h0, lim_eff} + 6'h01) * PCT_STEP);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            threshold_pct_q <= RST_PCT;
            unbalance_pct_q <= RST_PCT;
        end else if (s_lim <= LIM_MAX_LARGE) begin
            threshold_pct_q <= pct_sel; // RULE_04
            unbalance_pct_q <= pct_sel; // RULE_05
        end
    end
endmodule // ats_mode_ctrl

// >>> hdl/ats_pkg.sv
// constants and types of the transfer switch mode controller
// assumes a single 40 MHz clock domain
package ats_pkg;
    // clock and one-second tick
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam int TICK_W = 26;
    localparam int SEC_W = 9;
    // delay selector values in seconds
    localparam logic [8:0] DELAY_SEL0_S = 9'h000;
    localparam logic [8:0] DELAY_SEL1_S = 9'h005;
    localparam logic [8:0] DELAY_SEL2_S = 9'h00A;
    localparam logic [8:0] DELAY_SEL3_S = 9'h01E;
    localparam logic [8:0] BACK_FIXED_S = 9'h12C;
    // threshold selector positions
    localparam logic [2:0] LIM_MAX_BASIC = 3'h3;
    localparam logic [2:0] LIM_MAX_LARGE = 3'h5;
    localparam logic [2:0] LIM_SETUP = 3'h6;
    localparam logic [2:0] LIM_TEST = 3'h7;
    localparam logic [5:0] PCT_STEP = 6'h05;
    localparam logic [5:0] RST_PCT = 6'h05;
    // setup combinations: priority index plus three times the switch type
    localparam logic [2:0] SETUP_LAST = 3'h5;
    localparam logic [2:0] SETUP_TYPES_SPLIT = 3'h3;
    localparam logic [2:0] RST_SETUP_SEL = 3'h0;
    localparam int SYNC_W = 25;

    typedef enum logic [3:0] {
        MODE_MANUAL = 4'b0001,
        MODE_AUTO = 4'b0010,
        MODE_SETUP = 4'b0100,
        MODE_TEST = 4'b1000
    } op_mode_type;

    typedef enum logic [1:0] {
        PRIO_LINE1 = 2'h0,
        PRIO_NONE = 2'h1,
        PRIO_MANBACK = 2'h2,
        PRIO_LINE2 = 2'h3
    } prio_type;

    typedef enum logic [3:0] {
        POS_HOLD = 4'b0001,
        POS_ONE = 4'b0010,
        POS_OFF = 4'b0100,
        POS_TWO = 4'b1000
    } pos_type;

    typedef enum logic [3:0] {
        TEST_GEN_START = 4'b0001,
        TEST_TO_TWO = 4'b0010,
        TEST_TO_ONE = 4'b0100,
        TEST_GEN_STOP = 4'b1000
    } test_step_type;
endpackage

// >>> hdl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are static or slow compared with clk
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins and synchronised copies
    input wire logic [W-1:0] pin,
    output logic [W-1:0] sync
);
    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) begin
            $error("pin_sync width must be at least one");
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync <= '0;
        end else begin
            meta_q <= pin;
            sync <= meta_q;
        end
    end
endmodule // pin_sync

// >>> verification/ats_partner.sv
// motor operator and auxiliary contact model for the change-over switch
// assumes switch commands are levels held until the position is reached
`timescale 1ns/1ps
module ats_partner #(
    parameter int MOVE = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // commands from the controller
    input wire logic motor_power_q,
    input wire logic cmd_one_q,
    input wire logic cmd_off_q,
    input wire logic cmd_two_q,
    // auxiliary contacts
    output logic sw_one_q,
    output logic sw_two_q
);
    logic [7:0] cnt_q;
    // contacts open as travel starts; the target closes on the edge after the count reaches MOVE, MOVE+1 cycles in
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            sw_one_q <= 1'b1;
            sw_two_q <= 1'b0;
        end else if (motor_power_q && (cmd_one_q || cmd_off_q || cmd_two_q)) begin
            if (cnt_q != 8'(MOVE)) begin
                cnt_q <= cnt_q + 8'h01;
            end
            sw_one_q <= (cnt_q == 8'(MOVE)) && cmd_one_q;
            sw_two_q <= (cnt_q == 8'(MOVE)) && cmd_two_q && !cmd_one_q;
        end else begin
            cnt_q <= 8'h00;
        end
    end
endmodule // ats_partner

// >>> verification/ats_mode_ctrl_chk.sv
// port checker of the transfer switch mode controller
// assumes it is bound into ats_mode_ctrl, one clock domain
`timescale 1ns/1ps
module ats_mode_ctrl_chk
    import ats_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched inputs
    input wire logic key_auto,
    input wire logic [2:0] lim_sel,
    input wire logic display_variant,
    input wire logic handle_sense_input,
    input wire logic motor_manual_sel,
    // watched outputs
    input wire logic cmd_one_q,
    input wire logic cmd_off_q,
    input wire logic cmd_two_q,
    input wire logic motor_power_q,
    input wire logic gen_start_q,
    input wire logic gen_stop_q,
    input wire logic auto_led_q,
    input wire logic alarm_led_q,
    input wire logic power_led_q,
    input wire logic setup_active_q,
    input wire logic test_active_q,
    input wire logic [5:0] threshold_pct_q,
    input wire logic [5:0] unbalance_pct_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    motor_cut_a: assert property ($rose(motor_manual_sel) |-> ##[1:4] !motor_power_q)
        else $error("motor power not cut");
    cmd_block_a: assert property (motor_manual_sel [*4] |-> !cmd_one_q && !cmd_off_q && !cmd_two_q)
        else $error("command while motor selector manual");
    pct_same_a: assert property (threshold_pct_q == unbalance_pct_q)
        else $error("unbalance differs from threshold");
    handle_on_a: assert property ($rose(handle_sense_input) |->
        ##[1:4] (alarm_led_q && power_led_q && !auto_led_q))
        else $error("handle attach indication wrong");
    handle_off_a: assert property ($fell(handle_sense_input) |-> ##[1:4] (!alarm_led_q && !auto_led_q))
        else $error("handle removal indication wrong");
    setup_entry_a: assert property ($rose(setup_active_q) |->
        !$past(auto_led_q) && $past(lim_sel, 2) == LIM_SETUP)
        else $error("setup entered outside manual");
    auto_entry_a: assert property ($rose(auto_led_q) |->
        ($past(key_auto, 3) || $past(key_auto, 4)) && !handle_sense_input)
        else $error("auto mode without key or with handle");
    gen_manual_a: assert property ((!display_variant && !auto_led_q && !test_active_q) [*4] |->
        !gen_start_q && !gen_stop_q)
        else $error("generator driven in manual mode");
endmodule // ats_mode_ctrl_chk
bind ats_mode_ctrl ats_mode_ctrl_chk u_ats_mode_ctrl_chk (.clk, .nrst, .key_auto, .lim_sel,
    .display_variant, .handle_sense_input, .motor_manual_sel, .cmd_one_q, .cmd_off_q, .cmd_two_q,
    .motor_power_q, .gen_start_q, .gen_stop_q, .auto_led_q, .alarm_led_q, .power_led_q,
    .setup_active_q, .test_active_q, .threshold_pct_q, .unbalance_pct_q);

// >>> verification/tb_top.sv
// testbench of the transfer switch mode controller with motor operator model
// assumes a one-second tick of 10 cycles so delays are 10 cycles a second
`timescale 1ns/1ps
module tb_top;
    import ats_pkg::*;
    logic clk = 1'b0, nrst = 1'b0;
    logic [5:0] keys = 6'h00; // auto, one, off, two, gen start, gen stop
    logic [1:0] dsel = 2'h0;
    logic drng = 1'b0, vlarge = 1'b0, disp = 1'b0, gen = 1'b0, mback = 1'b0;
    logic hnd = 1'b0, mman = 1'b0, l1 = 1'b1, l2 = 1'b1;
    logic [2:0] lim = 3'h0;
    prio_type prio = PRIO_LINE1;
    logic sw1, sw2, c1, c0, c2, mpw, gs, gp, aled, alm, pwl, msl, sact, tact;
    logic [2:0] pled;
    logic [5:0] thr, unb;
    int err_total = 0, n_compared = 0, cyc = 0;
    // lim, large variant, expected percent
    logic [9:0] rows [8] = '{10'h005, 10'h0CA, 10'h10F, 10'h194, 10'h214, 10'h259, 10'h2DE,
        10'h294};
    ats_mode_ctrl #(.TICK_CYCLES_P(10)) u_ats_mode_ctrl (.clk(clk), .nrst(nrst),
        .key_auto(keys[0]), .key_one(keys[1]), .key_off(keys[2]), .key_two(keys[3]),
        .key_gen_start(keys[4]), .key_gen_stop(keys[5]), .delay_sel(dsel), .delay_range(drng),
        .lim_sel(lim), .variant_large(vlarge), .display_variant(disp), .gen_in_use(gen),
        .cfg_priority(prio), .cfg_motorized(1'b0), .cfg_manual_back(mback),
        .handle_sense_input(hnd), .motor_manual_sel(mman), .switch_one_status(sw1),
        .switch_two_status(sw2), .line_one_ok(l1), .line_two_ok(l2), .cmd_one_q(c1),
        .cmd_off_q(c0), .cmd_two_q(c2), .motor_power_q(mpw), .gen_start_q(gs),
        .gen_stop_q(gp), .auto_led_q(aled), .alarm_led_q(alm), .power_led_q(pwl),
        .prio_led_q(pled), .motorized_led_q(msl), .setup_active_q(sact),
        .test_active_q(tact), .threshold_pct_q(thr), .unbalance_pct_q(unb));
    ats_partner u_ats_partner (.clk(clk), .nrst(nrst), .motor_power_q(mpw), .cmd_one_q(c1),
        .cmd_off_q(c0), .cmd_two_q(c2), .sw_one_q(sw1), .sw_two_q(sw2));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk_bit(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task chk_vec(input logic [5:0] got, input logic [5:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %0h", $time, m, got);
        end
    endtask
    task press(input int k);
        @(negedge clk);
        keys[k] = 1'b1;
        repeat (3) @(negedge clk);
        keys[k] = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // waits for the contacts to settle, bounded, then compares them
    task wait_sw(input logic e1, input logic e2, input int n);
        for (int i = 0; i < n && !(sw1 === e1 && sw2 === e2); i++) @(negedge clk);
        chk_bit(sw1, e1, "switch one");
        chk_bit(sw2, e2, "switch two");
    endtask
    task done(input string t);
        $display("test %s done", t);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        chk_vec(thr, 6'h05, "reset threshold");
        chk_bit(aled, 1'b0, "reset auto led");
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit(pwl, 1'b1, "power led");
        done("reset");
        for (int i = 0; i < 8; i++) begin
            {lim, vlarge} = rows[i][9:6];
            repeat (6) @(negedge clk);
            chk_vec(thr, rows[i][5:0], "threshold");
            chk_vec(unb, rows[i][5:0], "unbalance");
        end
        lim = LIM_SETUP;
        repeat (6) @(negedge clk);
        chk_bit(sact, 1'b1, "setup entry");
        for (int i = 1; i < 7; i++) begin
            press(0);
            chk_vec({3'h0, pled}, 6'(3'h1 << (i % 6 % 3)), "priority led");
            chk_bit(msl, i % 6 >= 3, "type led");
        end
        lim = 3'h0;
        repeat (6) @(negedge clk);
        chk_bit(sact, 1'b0, "setup exit");
        done("setup");
        gen = 1'b1;
        lim = LIM_TEST;
        repeat (6) @(negedge clk);
        chk_bit(tact, 1'b1, "test entry");
        press(0);
        chk_bit(gs, 1'b1, "test gen start");
        press(0);
        wait_sw(1'b0, 1'b1, 40);
        press(0);
        wait_sw(1'b1, 1'b0, 40);
        press(0);
        chk_bit(gp, 1'b1, "test gen stop");
        press(0);
        chk_bit(gs, 1'b1, "test restart");
        gen = 1'b0;
        press(0);
        wait_sw(1'b0, 1'b1, 40);
        press(0);
        wait_sw(1'b1, 1'b0, 40);
        press(0);
        wait_sw(1'b0, 1'b1, 40);
        lim = 3'h0;
        repeat (6) @(negedge clk);
        chk_bit(tact, 1'b0, "test exit");
        chk_bit(aled, 1'b0, "manual after test");
        press(0);
        chk_bit(aled, 1'b1, "auto after test");
        wait_sw(1'b1, 1'b0, 100);
        done("test");
        dsel = 2'h1;
        l1 = 1'b0;
        repeat (35) @(negedge clk);
        chk_bit(sw1, 1'b1, "switch delay early");
        l1 = 1'b1;
        repeat (10) @(negedge clk);
        l1 = 1'b0;
        repeat (45) @(negedge clk);
        chk_bit(sw1, 1'b1, "timer restart");
        wait_sw(1'b0, 1'b1, 60);
        l1 = 1'b1;
        repeat (35) @(negedge clk);
        chk_bit(sw2, 1'b1, "back delay early");
        wait_sw(1'b1, 1'b0, 60);
        drng = 1'b1;
        dsel = 2'h3;
        l1 = 1'b0;
        repeat (280) @(negedge clk);
        chk_bit(sw1, 1'b1, "long switch delay");
        wait_sw(1'b0, 1'b1, 120);
        l1 = 1'b1;
        repeat (2900) @(negedge clk);
        chk_bit(sw2, 1'b1, "fixed back delay");
        wait_sw(1'b1, 1'b0, 300);
        done("delays");
        hnd = 1'b1;
        repeat (6) @(negedge clk);
        chk_bit(alm, 1'b1, "alarm with handle");
        chk_bit(aled, 1'b0, "auto off with handle");
        press(0);
        chk_bit(aled, 1'b0, "auto refused with handle");
        hnd = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit(alm, 1'b0, "alarm after removal");
        press(3);
        wait_sw(1'b0, 1'b1, 40);
        press(2);
        wait_sw(1'b0, 1'b0, 40);
        press(1);
        wait_sw(1'b1, 1'b0, 40);
        press(0);
        chk_bit(aled, 1'b1, "auto after removal");
        done("handle");
        drng = 1'b0;
        dsel = 2'h1;
        disp = 1'b1;
        prio = PRIO_NONE;
        l1 = 1'b0;
        wait_sw(1'b0, 1'b1, 90);
        l1 = 1'b1;
        repeat (150) @(negedge clk);
        chk_bit(sw2, 1'b1, "stay on line two");
        l2 = 1'b0;
        wait_sw(1'b1, 1'b0, 90);
        l2 = 1'b1;
        mback = 1'b1;
        l1 = 1'b0;
        wait_sw(1'b0, 1'b1, 90);
        l1 = 1'b1;
        repeat (150) @(negedge clk);
        chk_bit(sw2, 1'b1, "no automatic back");
        l2 = 1'b0;
        wait_sw(1'b0, 1'b0, 90);
        mman = 1'b1;
        repeat (6) @(negedge clk);
        chk_bit(mpw, 1'b0, "motor unpowered");
        hnd = 1'b1;
        press(4);
        chk_bit(gs, 1'b1, "manual gen start");
        press(5);
        chk_bit(gp, 1'b1, "manual gen stop");
        done("priority");
        print_verdict();
    end
endmodule // tb_top
